// [logic/cmc_blink.sv]
`timescale 1ns/10ps
`default_nettype none

module cmc_blink #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             tick_i,
  input  wire logic             restart_i,
  input  wire logic [CNT_W-1:0] period_i,
  input  wire logic [CNT_W-1:0] on_i,
  output logic                  blink_o
);

  logic [CNT_W-1:0] cnt_ff;     // Ticks into current period
  logic [CNT_W-1:0] nxt_cnt;
  logic             blink_ff;   // Lamp level for this period phase
  logic             nxt_blink;
  logic             wrap;

  // Wrap at the end of the period
  assign wrap      = (cnt_ff >= period_i - CNT_W'(1));
  // Restart lights the lamp at once, so a mode change is seen quickly
  assign nxt_cnt   = restart_i ? '0 : (tick_i ? (wrap ? '0 : cnt_ff + CNT_W'(1)) : cnt_ff);
  assign nxt_blink = (nxt_cnt < on_i);
  assign blink_o   = blink_ff;

  // Tick counter and lamp register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_ff   <= '0;
      blink_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      blink_ff <= nxt_blink;
    end
  end

endmodule

`default_nettype wire

// [logic/cmc_modem_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

module cmc_modem_ctrl #(
  parameter int unsigned TICK_CYCLES = cmc_pkg::TICK_CYCLES
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  // Host memory bus pins
  input  wire logic [cmc_pkg::ADDR_W-1:0] host_addr_i,
  input  wire logic                       host_cs_n_i,
  input  wire logic                       host_we_n_i,
  input  wire logic                       host_oe_n_i,
  // Host serial port
  input  wire logic                       host_txd_i,
  output logic                            host_rxd_o,
  // Modem serial port
  output logic                            modem_rxd_o,
  input  wire logic                       modem_txd_i,
  // Off-board serial pins used while the modem is detached
  output logic                            ext_txd_o,
  input  wire logic                       ext_rxd_i,
  // Modem power and status
  output logic                            modem_power_on_o,
  input  wire logic [1:0]                 modem_state_i,
  output logic                            modem_status_led_o,
  // SIM socket
  input  wire logic                       sim_card_detect_n_i,
  output logic                            sim_present_o,
  // Wireless radio activity
  input  wire logic                       wireless_rx_i,
  input  wire logic                       wireless_tx_i,
  output logic                            wireless_activity_out_o,
  // Read-back of the serial routing state for board logic
  output logic                            serial_connected_o
);

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

  // ---------------------------------------------------------------
  // Pin synchronisers: first stage feeds only the second stage
  // ---------------------------------------------------------------
  logic [cmc_pkg::ADDR_W-1:0] addr_s1_ff;   // Address, stage one
  logic [cmc_pkg::ADDR_W-1:0] addr_s2_ff;   // Address, stage two
  logic [2:0]                 bus_s1_ff;    // cs, we, oe, stage one
  logic [2:0]                 bus_s2_ff;    // cs, we, oe, stage two
  logic [6:0]                 pin_s1_ff;    // Misc pins, stage one
  logic [6:0]                 pin_s2_ff;    // Misc pins, stage two
  logic [1:0]                 mst_s1_ff;    // Modem state, stage one
  logic [1:0]                 mst_s2_ff;    // Modem state, stage two

  // Two flops on every pin input
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      addr_s1_ff <= '0;
      addr_s2_ff <= '0;
      bus_s1_ff  <= 3'h7;
      bus_s2_ff  <= 3'h7;
      pin_s1_ff  <= 7'h1f;   // Idle levels: serial mark, no card, radio quiet
      pin_s2_ff  <= 7'h1f;   // Avoids a false card-present pulse after reset
      mst_s1_ff  <= cmc_pkg::MST_OFF;
      mst_s2_ff  <= cmc_pkg::MST_OFF;
    end else begin
      addr_s1_ff <= host_addr_i;
      addr_s2_ff <= addr_s1_ff;
      bus_s1_ff  <= {host_oe_n_i, host_we_n_i, host_cs_n_i};
      bus_s2_ff  <= bus_s1_ff;
      pin_s1_ff  <= {wireless_tx_i, wireless_rx_i, sim_card_detect_n_i,
                     ext_rxd_i, modem_txd_i, host_txd_i, 1'b1};
      pin_s2_ff  <= pin_s1_ff;
      mst_s1_ff  <= modem_state_i;
      mst_s2_ff  <= mst_s1_ff;
    end
  end

  // Named views of the synchronised pins
  wire logic cs_n_s     = bus_s2_ff[0];
  wire logic we_n_s     = bus_s2_ff[1];
  wire logic oe_n_s     = bus_s2_ff[2];
  wire logic h_txd_s    = pin_s2_ff[1];
  wire logic m_txd_s    = pin_s2_ff[2];
  wire logic e_rxd_s    = pin_s2_ff[3];
  wire logic sim_det_s  = pin_s2_ff[4];
  wire logic wl_rx_s    = pin_s2_ff[5];
  wire logic wl_tx_s    = pin_s2_ff[6];

  // ---------------------------------------------------------------
  // Control word write decode
  // ---------------------------------------------------------------
  logic [cmc_pkg::ADDR_W-1:0] wr_addr_ff;   // Address held during strobe
  logic                       wr_act_ff;    // Write strobe seen last cycle
  cmc_pkg::cmc_ctrl_type      ctrl_ff;      // Latched control word
  cmc_pkg::cmc_ctrl_type      nxt_ctrl;

  // Only a write strobe counts; the read strobe feeds only rd_seen, never the decode
  wire logic wr_act   = ~cs_n_s & ~we_n_s;
  // Bits that carry data are masked out of the compare
  wire logic addr_hit = ((wr_addr_ff & ~cmc_pkg::CTRL_DATA_MASK)
                         == cmc_pkg::CTRL_ADDR);
  // Take the write as the strobe ends; address was stable throughout,
  // which avoids sampling bits skewed by the synchroniser
  wire logic wr_take  = wr_act_ff & ~wr_act & addr_hit;
  wire logic rd_seen  = ~cs_n_s & ~oe_n_s;

  // Data bits come from the address lines, not the data bus
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_take) begin
      nxt_ctrl.serial_connect = wr_addr_ff[cmc_pkg::SERIAL_BIT];
      nxt_ctrl.power_on       = wr_addr_ff[cmc_pkg::POWER_BIT];
    end
  end

  // Strobe tracking, address hold and control latch
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_addr_ff <= '0;
      wr_act_ff  <= 1'b0;
      ctrl_ff    <= cmc_pkg::CTRL_RESET;
    end else begin
      if (wr_act) begin
        wr_addr_ff <= addr_s2_ff;
      end
      wr_act_ff  <= wr_act;
      ctrl_ff    <= nxt_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // Serial routing
  // ---------------------------------------------------------------
  logic host_rxd_ff;    // Host receive line
  logic modem_rxd_ff;   // Modem receive line
  logic ext_txd_ff;     // Off-board transmit line
  logic nxt_host_rxd;
  logic nxt_modem_rxd;
  logic nxt_ext_txd;

  // Connected: host and modem face each other, off-board pins idle.
  // Detached: host port goes to the off-board pins, modem line idles.
  assign nxt_modem_rxd = ctrl_ff.serial_connect ? h_txd_s : cmc_pkg::UART_IDLE;
  assign nxt_ext_txd   = ctrl_ff.serial_connect ? cmc_pkg::UART_IDLE : h_txd_s;
  assign nxt_host_rxd  = ctrl_ff.serial_connect ? m_txd_s : e_rxd_s;

  // Registered so every output leaves a flop; costs a few cycles of
  // latency, harmless at serial bit rates far below the clock
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      host_rxd_ff  <= cmc_pkg::UART_IDLE;
      modem_rxd_ff <= cmc_pkg::UART_IDLE;
      ext_txd_ff   <= cmc_pkg::UART_IDLE;
    end else begin
      host_rxd_ff  <= nxt_host_rxd;
      modem_rxd_ff <= nxt_modem_rxd;
      ext_txd_ff   <= nxt_ext_txd;
    end
  end

  // ---------------------------------------------------------------
  // Blink time base: one-cycle tick every TICK_CYCLES clocks
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] div_ff;    // Divider count
  logic [TICK_W-1:0] nxt_div;
  logic              tick_ff;   // Tick enable pulse
  wire  logic        div_end = (div_ff == TICK_W'(TICK_CYCLES - 1));

  assign nxt_div = div_end ? '0 : div_ff + TICK_W'(1);

  // Divider
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= div_end;
    end
  end

  // ---------------------------------------------------------------
  // Status indicator
  // ---------------------------------------------------------------
  cmc_pkg::cmc_led_type led_mode_ff;    // Current indicator mode
  cmc_pkg::cmc_led_type nxt_led_mode;
  logic                 led_ff;         // Indicator output level
  logic                 nxt_led;
  logic                 blink;          // Pattern generator output
  logic [7:0]           period_sel;     // Period for current mode
  logic [7:0]           on_sel;         // On time for current mode

  // Modem state to indicator mode
  always_comb begin
    unique case (mst_s2_ff)
      cmc_pkg::MST_OFF:        nxt_led_mode = cmc_pkg::LED_OFF;
      cmc_pkg::MST_SEARCH:     nxt_led_mode = cmc_pkg::LED_FAST;
      cmc_pkg::MST_REGISTERED: nxt_led_mode = cmc_pkg::LED_SLOW;
      cmc_pkg::MST_CALL:       nxt_led_mode = cmc_pkg::LED_STEADY;
    endcase
  end

  // Pattern timing for the blinking modes
  assign period_sel = (led_mode_ff == cmc_pkg::LED_SLOW) ?
                      cmc_pkg::SLOW_PERIOD_T : cmc_pkg::FAST_PERIOD_T;
  assign on_sel     = (led_mode_ff == cmc_pkg::LED_SLOW) ?
                      cmc_pkg::SLOW_ON_T : cmc_pkg::FAST_ON_T;

  // Pattern restarts whenever the mode changes
  wire logic mode_change = (nxt_led_mode != led_mode_ff);

  cmc_blink #(
    .CNT_W     (cmc_pkg::BLINK_W)
  ) u_blink (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .tick_i    (tick_ff),
    .restart_i (mode_change),
    .period_i  (period_sel),
    .on_i      (on_sel),
    .blink_o   (blink)
  );

  // Output level per mode; high means lit
  always_comb begin
    unique case (led_mode_ff)
      cmc_pkg::LED_OFF:    nxt_led = 1'b0;
      cmc_pkg::LED_FAST:   nxt_led = blink;
      cmc_pkg::LED_SLOW:   nxt_led = blink;
      cmc_pkg::LED_STEADY: nxt_led = 1'b1;
      default:             nxt_led = 1'b0;
    endcase
  end

  // Mode and active-high indicator register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      led_mode_ff <= cmc_pkg::LED_OFF;
      led_ff      <= 1'b0;
    end else begin
      led_mode_ff <= nxt_led_mode;
      led_ff      <= nxt_led;
    end
  end

  // ---------------------------------------------------------------
  // SIM presence and wireless activity
  // ---------------------------------------------------------------
  logic sim_present_ff;   // Card seen in socket
  logic wl_act_ff;        // Radio receiving or sending
  logic rd_seen_ff;       // Read strobe observed, feeds only unused_ok

  // A low detect means a card is inserted; polled every cycle so hot
  // insertion and removal both show within the synchroniser delay
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sim_present_ff <= 1'b0;
      wl_act_ff      <= 1'b0;
      rd_seen_ff     <= 1'b0;
    end else begin
      sim_present_ff <= ~sim_det_s;
      wl_act_ff      <= wl_rx_s | wl_tx_s;
      rd_seen_ff     <= rd_seen;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flops
  // ---------------------------------------------------------------
  // Power-on follows the latch; software owns the pulse length, so a
  // short pulse is passed on unchanged and may fail to start the modem
  assign modem_power_on_o        = ctrl_ff.power_on;
  assign serial_connected_o      = ctrl_ff.serial_connect;
  assign host_rxd_o              = host_rxd_ff;
  assign modem_rxd_o             = modem_rxd_ff;
  assign ext_txd_o               = ext_txd_ff;
  assign modem_status_led_o      = led_ff;
  assign sim_present_o           = sim_present_ff;
  assign wireless_activity_out_o = wl_act_ff;

  // Read strobes never reach the control latch
  wire logic unused_ok = rd_seen_ff & pin_s2_ff[0];

endmodule

`default_nettype wire

// [logic/cmc_pkg.sv]
package cmc_pkg;

  // Host physical address width seen on the bus pins
  localparam int unsigned ADDR_W         = 27;
  // Control word location; the two data bits ride on address lines
  localparam logic [26:0] CTRL_ADDR      = 27'h5200000;
  localparam int unsigned SERIAL_BIT     = 17;
  localparam int unsigned POWER_BIT      = 19;
  // Address lines that carry data are left out of the decode
  localparam logic [26:0] CTRL_DATA_MASK = 27'h00a0000;

  // Clock and blink time base
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;

  // Blink patterns, times in milliseconds, then in ticks
  localparam int unsigned FAST_PERIOD_MS = 1000;
  localparam int unsigned FAST_ON_MS     = 500;
  localparam int unsigned SLOW_PERIOD_MS = 3000;
  localparam int unsigned SLOW_ON_MS     = 300;
  localparam int unsigned BLINK_W        = 8;
  localparam logic [7:0]  FAST_PERIOD_T  = 8'(FAST_PERIOD_MS / TICK_MS);
  localparam logic [7:0]  FAST_ON_T      = 8'(FAST_ON_MS / TICK_MS);
  localparam logic [7:0]  SLOW_PERIOD_T  = 8'(SLOW_PERIOD_MS / TICK_MS);
  localparam logic [7:0]  SLOW_ON_T      = 8'(SLOW_ON_MS / TICK_MS);

  // Modem activity state as reported by the modem core
  localparam logic [1:0]  MST_OFF        = 2'h0;
  localparam logic [1:0]  MST_SEARCH     = 2'h1;
  localparam logic [1:0]  MST_REGISTERED = 2'h2;
  localparam logic [1:0]  MST_CALL       = 2'h3;

  // Idle level of a serial line (mark)
  localparam logic        UART_IDLE      = 1'b1;

  // Control word carried as one unit
  typedef struct packed {
    logic power_on;
    logic serial_connect;
  } cmc_ctrl_type;

  localparam cmc_ctrl_type CTRL_RESET    = '{power_on: 1'b0, serial_connect: 1'b0};

  // Status indicator modes, one-hot
  typedef enum logic [3:0] {
    LED_OFF    = 4'h1,
    LED_FAST   = 4'h2,
    LED_SLOW   = 4'h4,
    LED_STEADY = 4'h8
  } cmc_led_type;

endpackage

// [testbench/cmc_modem_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Behavioural cellular modem on the far side of the block
module cmc_modem_model #(
  parameter int unsigned HOLD = 20 // Scaled stand-in for one second
) (
  input  wire logic       ref_clk_i,
  input  wire logic       power_on_i,
  input  wire logic       rxd_i,
  input  wire logic       card_in_i,
  input  wire logic [1:0] state_i,
  output logic            txd_o,
  output logic [1:0]      state_o,
  output logic            card_detect_n_o
);
  logic       on_ff = 1'b0;   // Modem running; power-down not modelled
  logic [7:0] hold_ff = 8'h00; // Length of current power-on pulse
  // Reports the commanded network state only while running
  assign state_o = on_ff ? state_i : cmc_pkg::MST_OFF;
  // Socket pulls detect low with a card, pull-up otherwise
  assign card_detect_n_o = !card_in_i;
  // Starts only on a long enough pulse; echoes serial data
  always_ff @(posedge ref_clk_i) begin
    // Count saturates so a very long pulse still counts as long
    hold_ff <= power_on_i ? ((&hold_ff) ? hold_ff : hold_ff + 8'h01) : 8'h00;
    if (!power_on_i && hold_ff >= 8'(HOLD)) begin
      on_ff <= 1'b1;
    end
    txd_o <= on_ff ? rxd_i : cmc_pkg::UART_IDLE;
  end
endmodule
`default_nettype wire

// [testbench/cmc_props.sv]
`timescale 1ns/10ps
`default_nettype none
// Pin-level checker for the modem control block
module cmc_props (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [26:0] host_addr_i,
  input wire logic        host_cs_n_i,
  input wire logic        host_we_n_i,
  input wire logic        host_txd_i,
  input wire logic        host_rxd_o,
  input wire logic        modem_rxd_o,
  input wire logic        modem_txd_i,
  input wire logic        ext_txd_o,
  input wire logic        ext_rxd_i,
  input wire logic        modem_power_on_o,
  input wire logic [1:0]  modem_state_i,
  input wire logic        modem_status_led_o,
  input wire logic        sim_card_detect_n_i,
  input wire logic        sim_present_o,
  input wire logic        wireless_rx_i,
  input wire logic        wireless_tx_i,
  input wire logic        wireless_activity_out_o,
  input wire logic        serial_connected_o
);
  logic [26:0]           adr_ff;   // Address one cycle back
  logic                  we_ff;    // Strobes one cycle back
  logic                  cs_ff;
  logic [2:0]            rdy_ff;   // Settling after reset
  logic [7:0]            since_ff; // Cycles since decoded write
  cmc_pkg::cmc_ctrl_type exp_ff;   // Bits that write carried
  // Pipelines hold reset values for a few cycles
  wire ok = (rdy_ff == 3'h4);
  // Write ends where strobe is first seen high
  wire hit = ok && host_we_n_i && !we_ff && !cs_ff &&
    ((adr_ff & ~cmc_pkg::CTRL_DATA_MASK) == cmc_pkg::CTRL_ADDR);
  // Pin history and write bookkeeping
  always_ff @(posedge ref_clk_i) begin
    adr_ff <= host_addr_i;
    we_ff <= host_we_n_i;
    cs_ff <= host_cs_n_i;
    if (reset_i) begin
      rdy_ff <= 3'h0;
      since_ff <= 8'hff;
    end else begin
      rdy_ff <= ok ? rdy_ff : rdy_ff + 3'h1;
      since_ff <= hit ? 8'h00 : (&since_ff ? since_ff : since_ff + 8'h01);
    end
    if (hit) begin
      exp_ff.power_on <= adr_ff[cmc_pkg::POWER_BIT];
      exp_ff.serial_connect <= adr_ff[cmc_pkg::SERIAL_BIT];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_pwr_write;
    hit |-> ##6 modem_power_on_o == exp_ff.power_on;
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power-on level differs from written bit");
  property p_ser_write;
    hit |-> ##6 serial_connected_o == exp_ff.serial_connect;
  endproperty
  a_ser_write: assert property (p_ser_write)
    else $error("serial routing differs from written bit");
  // Reads and foreign addresses must leave the bits alone
  property p_ctrl_cause;
    ok && ($changed(modem_power_on_o) || $changed(serial_connected_o))
      |-> since_ff inside {[8'h01:8'h06]};
  endproperty
  a_ctrl_cause: assert property (p_ctrl_cause)
    else $error("control bits moved without a decoded write");
  property p_detached;
    (ok && !serial_connected_o)[*5] |-> ext_txd_o == $past(host_txd_i, 3)
      && host_rxd_o == $past(ext_rxd_i, 3) && modem_rxd_o == cmc_pkg::UART_IDLE;
  endproperty
  a_detached: assert property (p_detached)
    else $error("detached serial port not routed off board");
  property p_attached;
    (ok && serial_connected_o)[*5] |-> modem_rxd_o == $past(host_txd_i, 3)
      && host_rxd_o == $past(modem_txd_i, 3) && ext_txd_o == cmc_pkg::UART_IDLE;
  endproperty
  a_attached: assert property (p_attached)
    else $error("attached serial port not routed to modem");
  property p_wireless;
    ok |-> wireless_activity_out_o == ($past(wireless_rx_i, 3) || $past(wireless_tx_i, 3));
  endproperty
  a_wireless: assert property (p_wireless)
    else $error("radio activity output wrong");
  property p_sim;
    ok |-> sim_present_o == !$past(sim_card_detect_n_i, 3);
  endproperty
  a_sim: assert property (p_sim)
    else $error("card presence not the inverse of detect");
  property p_led_off;
    (modem_state_i == cmc_pkg::MST_OFF)[*8] |-> !modem_status_led_o;
  endproperty
  a_led_off: assert property (p_led_off)
    else $error("status LED lit while modem off");
  property p_led_call;
    (modem_state_i == cmc_pkg::MST_CALL)[*8] |-> modem_status_led_o;
  endproperty
  a_led_call: assert property (p_led_call)
    else $error("status LED dark during a call");
  c_write: cover property (hit);
  c_fast: cover property (modem_state_i == cmc_pkg::MST_SEARCH && $rose(modem_status_led_o));
  c_slow: cover property (modem_state_i == cmc_pkg::MST_REGISTERED && $rose(modem_status_led_o));
endmodule
bind cmc_modem_ctrl cmc_props i_cmc_props (.*);
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TICK = 10; // Shortened blink tick
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [26:0] host_addr_i = '0;
  logic        host_cs_n_i = 1'b1, host_we_n_i = 1'b1, host_oe_n_i = 1'b1;
  logic        host_txd_i = 1'b1, ext_rxd_i = 1'b1, card_in = 1'b0;
  logic        wireless_rx_i = 1'b0, wireless_tx_i = 1'b0;
  logic [1:0]  net_state = 2'h0;  // Network state asked of the modem
  wire logic   host_rxd_o, modem_rxd_o, ext_txd_o, modem_power_on_o, modem_txd;
  wire logic   modem_status_led_o, sim_present_o, wireless_activity_out_o;
  wire logic   serial_connected_o, sim_n;
  wire logic [1:0] modem_state;
  int          fails = 0, samples_checked = 0, cyc = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  cmc_modem_ctrl #(.TICK_CYCLES(TICK)) i_cmc_modem_ctrl (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .host_addr_i(host_addr_i),
    .host_cs_n_i(host_cs_n_i), .host_we_n_i(host_we_n_i), .host_oe_n_i(host_oe_n_i),
    .host_txd_i(host_txd_i), .host_rxd_o(host_rxd_o), .modem_rxd_o(modem_rxd_o),
    .modem_txd_i(modem_txd), .ext_txd_o(ext_txd_o), .ext_rxd_i(ext_rxd_i),
    .modem_power_on_o(modem_power_on_o), .modem_state_i(modem_state),
    .modem_status_led_o(modem_status_led_o), .sim_card_detect_n_i(sim_n),
    .sim_present_o(sim_present_o), .wireless_rx_i(wireless_rx_i),
    .wireless_tx_i(wireless_tx_i), .wireless_activity_out_o(wireless_activity_out_o),
    .serial_connected_o(serial_connected_o));
  cmc_modem_model i_cmc_modem_model (.ref_clk_i(ref_clk_i),
    .power_on_i(modem_power_on_o), .rxd_i(modem_rxd_o), .card_in_i(card_in),
    .state_i(net_state), .txd_o(modem_txd), .state_o(modem_state),
    .card_detect_n_o(sim_n));
  task automatic check(string name, logic [8:0] got, logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write or read strobe held 4 clocks, address settled 2 clocks before it and kept until the next access
  task automatic bus(logic [26:0] a, logic rd);
    @(posedge ref_clk_i);
    host_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    host_cs_n_i <= 1'b0;
    host_we_n_i <= rd;
    host_oe_n_i <= !rd;
    repeat (4) @(posedge ref_clk_i);
    host_we_n_i <= 1'b1;
    host_oe_n_i <= 1'b1;
    @(posedge ref_clk_i);
    host_cs_n_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic ctrl(logic pwr, logic ser, logic [26:0] base, logic rd);
    logic [26:0] a;
    a = base;
    a[cmc_pkg::POWER_BIT] = pwr;
    a[cmc_pkg::SERIAL_BIT] = ser;
    bus(a, rd);
  endtask
  task automatic t_ctrl();
    for (int k = 0; k < 4; k++) begin
      ctrl(k[1], k[0], cmc_pkg::CTRL_ADDR, 1'b0);
      check("power_on", modem_power_on_o, k[1]);
      check("serial", serial_connected_o, k[0]);
    end
    ctrl(1'b0, 1'b0, cmc_pkg::CTRL_ADDR ^ 27'h0000004, 1'b0);
    check("foreign write", modem_power_on_o, 1'b1);
    ctrl(1'b0, 1'b0, cmc_pkg::CTRL_ADDR, 1'b1);
    check("read power", modem_power_on_o, 1'b1);
    check("read serial", serial_connected_o, 1'b1);
    ctrl(1'b0, 1'b0, cmc_pkg::CTRL_ADDR, 1'b0);
    check("cleared", modem_power_on_o, 1'b0);
    $display("control word test done");
  endtask
  // Pulse outlasts the modem's minimum hold before release
  task automatic t_power();
    ctrl(1'b1, 1'b1, cmc_pkg::CTRL_ADDR, 1'b0);
    repeat (30) @(posedge ref_clk_i);
    ctrl(1'b0, 1'b1, cmc_pkg::CTRL_ADDR, 1'b0);
    check("pulse end", modem_power_on_o, 1'b0);
    $display("power pulse test done");
  endtask
  task automatic t_serial();
    for (int k = 0; k < 4; k++) begin
      ctrl(1'b0, k[1], cmc_pkg::CTRL_ADDR, 1'b0);
      host_txd_i <= k[0];
      ext_rxd_i <= !k[0];
      repeat (12) @(negedge ref_clk_i);
      check("modem_rxd", modem_rxd_o, k[1] ? k[0] : 1'b1);
      check("host_rxd", host_rxd_o, k[1] ? k[0] : !k[0]);
      check("ext_txd", ext_txd_o, k[1] ? 1'b1 : k[0]);
    end
    $display("serial routing test done");
  endtask
  task automatic till(logic v, output int n);
    n = 0;
    while (modem_status_led_o !== v && n < 700) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  // Times one lit phase and one whole period of the pattern
  task automatic blink(logic [1:0] st, int on_t, int per_t);
    int n_on, n_off;
    @(posedge ref_clk_i);
    net_state <= st;
    till(1'b0, n_on);
    till(1'b1, n_on);
    till(1'b0, n_on);
    till(1'b1, n_off);
    check("led on", 9'(n_on), 9'(on_t * TICK));
    check("led period", 9'(n_on + n_off), 9'(per_t * TICK));
  endtask
  task automatic t_led();
    @(posedge ref_clk_i);
    net_state <= cmc_pkg::MST_OFF;
    repeat (12) @(negedge ref_clk_i);
    check("led off", modem_status_led_o, 1'b0);
    @(posedge ref_clk_i);
    net_state <= cmc_pkg::MST_CALL;
    repeat (12) @(negedge ref_clk_i);
    check("led call", modem_status_led_o, 1'b1);
    blink(cmc_pkg::MST_SEARCH, cmc_pkg::FAST_ON_T, cmc_pkg::FAST_PERIOD_T);
    blink(cmc_pkg::MST_REGISTERED, cmc_pkg::SLOW_ON_T, cmc_pkg::SLOW_PERIOD_T);
    $display("status LED test done");
  endtask
  task automatic t_misc();
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      card_in <= k[0];
      wireless_rx_i <= k[1];
      wireless_tx_i <= k[0] & !k[1];
      repeat (6) @(negedge ref_clk_i);
      check("sim", sim_present_o, k[0]);
      check("activity", wireless_activity_out_o, k[1] | k[0]);
    end
    $display("card and radio test done");
  endtask
  // Hang guard well above the expected run length
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check("reset sim", sim_present_o, 1'b0);
    repeat (2) @(negedge ref_clk_i);
    check("reset power", modem_power_on_o, 1'b0);
    check("reset serial", serial_connected_o, 1'b0);
    t_ctrl();
    t_power();
    t_serial();
    t_led();
    t_misc();
    print_verdict();
  end
endmodule
`default_nettype wire
